// ===== pkg/mis_pkg.sv
// Shared constants and types for the instruction subset execute unit.
package mis_pkg;
   localparam int AXI_AW = 8;
   localparam int PC_W   = 21;
   localparam int PTR_W  = 12;
   localparam int RA_W   = 12;

   // Register byte offsets on the AXI4-Lite port.
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_INSTR  = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_FLAGS  = 8'h0C;
   localparam logic [7:0] REG_WORK   = 8'h10;
   localparam logic [7:0] REG_BANK   = 8'h14;
   localparam logic [7:0] REG_PC     = 8'h18;
   localparam logic [7:0] REG_STACK_TOP = 8'h1C;
   localparam logic [7:0] REG_PTR0   = 8'h20;
   localparam logic [7:0] REG_PTR1   = 8'h24;
   localparam logic [7:0] REG_PTR2   = 8'h28;
   localparam logic [7:0] REG_SHADOW = 8'h2C;

   // Opcode patterns, matched against the top bits of the word.
   localparam logic [7:0] OP_BRANCH_ZERO = 8'hE0;
   localparam logic [6:0] OP_CALL  = 7'h76;
   localparam logic [7:0] OP_PTR   = 8'hE8;
   localparam logic [5:0] OP_RRNC  = 6'h10;
   localparam logic [6:0] OP_SET_ONES  = 7'h34;
   localparam logic [3:0] OP_BIT_CLEAR = 4'h9;
   localparam logic [3:0] OP_WORD2 = 4'hF;

   localparam logic [1:0] PTR_SEL_RET = 2'h3;
   localparam logic [1:0] PTR_TWO     = 2'h2;
   localparam int         FLAG_Z      = 2;
   localparam int         FLAG_N      = 4;
   localparam logic [7:0] ACCESS_LIMIT = 8'h5F;
   localparam logic [3:0] ACCESS_HI    = 4'hF;
   localparam logic [3:0] ACCESS_LO    = 4'h0;
   localparam logic [7:0] BYTE_ONES    = 8'hFF;
   localparam logic [7:0] BYTE_ZERO    = 8'h00;
   localparam logic [7:0] BIT_ONE      = 8'h01;
   localparam logic [PC_W-1:0] PC_STEP = 21'h000002;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef logic [1:0] mis_phase_t;
   localparam mis_phase_t PH_Q1   = 2'h0;
   localparam mis_phase_t PH_Q2   = 2'h1;
   localparam mis_phase_t PH_Q3   = 2'h2;
   localparam mis_phase_t PH_Q4   = 2'h3;
   localparam mis_phase_t PH_STEP = 2'h1;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'h1,
      ST_EXEC  = 4'h2,
      ST_WAIT2 = 4'h4,
      ST_NOP   = 4'h8
   } mis_state_t;
endpackage

// ===== design/mis_addr_map.sv
// Effective data address for byte and bit file operations.
`timescale 1ns/10ps
module mis_addr_map
(
   input  wire logic [7:0]                fadr,
   input  wire logic                      acc,
   input  wire logic                      ext,
   input  wire logic [3:0]                bank_select_reg,
   input  wire logic [mis_pkg::PTR_W-1:0] ptr2,
   output logic      [mis_pkg::RA_W-1:0]  ea
);
   import mis_pkg::*;

   // Access bank splits low RAM and the top page; bank mode uses the bank select.
   always_comb
   begin
      if (acc)
         ea = {bank_select_reg, fadr};
      else if (ext && (fadr <= ACCESS_LIMIT))
         ea = ptr2 + {ACCESS_LO, fadr};
      else if (fadr <= ACCESS_LIMIT)
         ea = {ACCESS_LO, fadr};
      else
         ea = {ACCESS_HI, fadr};
   end
endmodule

// ===== design/mis_exec_core.sv
// Instruction subset decode and execute unit behind an AXI4-Lite register port.
//
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
module mis_exec_core
(
   input  wire logic                       core_clk,
   input  wire logic                       sys_rst,
   input  wire logic [mis_pkg::AXI_AW-1:0] s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   input  wire logic [mis_pkg::AXI_AW-1:0] s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   output logic [31:0]                     s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   output logic [mis_pkg::RA_W-1:0]        rf_addr,
   output logic                            rf_re,
   output logic                            rf_we,
   output logic [7:0]                      rf_wdata,
   input  wire logic [7:0]                 rf_rdata
);
   import mis_pkg::*;

   typedef struct packed {
      mis_state_t             st;
      mis_phase_t             ph;
      logic [15:0]            ir;
      logic [7:0]             k_lo;
      logic                   call_s;
      logic                   call2;
      logic                   call_err;
      logic                   ext;
      logic [PC_W-1:0]        pc;
      logic [PC_W-1:0]        return_stack_top;
      logic [7:0]             w;
      logic [7:0]             flags;
      logic [3:0]             bank_select_reg;
      logic [7:0]             work_shadow;
      logic [7:0]             flags_shadow;
      logic [3:0]             bank_select_shadow;
      logic [2:0][PTR_W-1:0]  ptr;
      logic [7:0]             opnd;
      logic [7:0]             res;
      logic                   aw_full;
      logic [AXI_AW-1:0]      awaddr;
      logic                   w_full;
      logic [31:0]            wdata;
      logic [3:0]             wstrb;
      logic                   awready;
      logic                   wready;
      logic                   bvalid;
      logic [1:0]             bresp;
      logic                   arready;
      logic                   rvalid;
      logic [31:0]            rdata;
      logic [1:0]             rresp;
      logic [RA_W-1:0]        rf_addr;
      logic                   rf_re;
      logic                   rf_we;
      logic [7:0]             rf_wdata;
   } mis_regs_t;

   mis_regs_t q;
   mis_regs_t d;

   logic              branch_on_zero_op, op_call, op_ptr, op_ret, op_rrnc;
   logic              set_all_ones_op, bit_clear_op;
   logic              op_file, word2_ok, dest_file, zero_set;
   logic [PC_W-1:0]   branch_target, call_target;
   logic [1:0]        ptr_sel;
   logic [PTR_W-1:0]  ptr_sum, ptr_total;
   logic [7:0]        rot_opnd, bit_mask, bit_clear_val;
   logic [5:0]        lit6;
   logic [RA_W-1:0]   ea, idx_ea, bank_ea;

   // Register read value with a hit flag on top; misses answer as errors.
   function automatic logic [32:0] rd_val(input mis_regs_t s, input logic [AXI_AW-1:0] a);
      logic [32:0] r;
      r = {1'b1, 32'h00000000};
      case ({a[AXI_AW-1:2], 2'h0})
         REG_CTRL:   r[0] = s.ext;
         REG_INSTR:  r[15:0] = s.ir;
         REG_STATUS: r[11:0] = {s.st, 2'h0, s.ph, 1'b0, s.call_err,
                                s.st == ST_WAIT2, s.st != ST_IDLE};
         REG_FLAGS:  r[7:0] = s.flags;
         REG_WORK:   r[7:0] = s.w;
         REG_BANK:   r[3:0] = s.bank_select_reg;
         REG_PC:     r[PC_W-1:0] = s.pc;
         REG_STACK_TOP: r[PC_W-1:0] = s.return_stack_top;
         REG_PTR0:   r[PTR_W-1:0] = s.ptr[0];
         REG_PTR1:   r[PTR_W-1:0] = s.ptr[1];
         REG_PTR2:   r[PTR_W-1:0] = s.ptr[2];
         REG_SHADOW: r[19:0] = {s.bank_select_shadow, s.flags_shadow, s.work_shadow};
         default:    r = 33'h000000000;
      endcase
      return r;
   endfunction

   // Byte lanes without a strobe keep their old contents.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (be[i])
            r[8*i +: 8] = nw[8*i +: 8];
      return r;
   endfunction

   // Decode is held off while the second call word sits in the instruction register.
   assign branch_on_zero_op = !q.call2 && (q.ir[15:8] == OP_BRANCH_ZERO);
   assign op_call   = !q.call2 && (q.ir[15:9] == OP_CALL);
   assign op_ptr    = !q.call2 && (q.ir[15:8] == OP_PTR);
   assign op_ret    = op_ptr && (q.ir[7:6] == PTR_SEL_RET);
   assign op_rrnc   = !q.call2 && (q.ir[15:10] == OP_RRNC);
   assign set_all_ones_op = !q.call2 && (q.ir[15:9] == OP_SET_ONES);
   assign bit_clear_op    = !q.call2 && (q.ir[15:12] == OP_BIT_CLEAR);
   assign op_file   = op_rrnc || set_all_ones_op || bit_clear_op;
   assign word2_ok  = q.ir[15:12] == OP_WORD2;
   assign dest_file = !op_rrnc || q.ir[9];
   assign zero_set  = q.flags[FLAG_Z];
   assign branch_target = q.pc + {{12{q.ir[7]}}, q.ir[7:0], 1'b0};
   assign call_target = {q.ir[11:0], q.k_lo, 1'b0};
   assign ptr_sel   = (q.ir[7:6] == PTR_SEL_RET) ? PTR_TWO : q.ir[7:6];
   assign lit6      = q.ir[5:0];
   assign ptr_sum   = q.ptr[ptr_sel] + {6'h00, lit6};
   assign ptr_total = q.ptr[0] + q.ptr[1] + q.ptr[2];
   assign rot_opnd  = {q.opnd[0], q.opnd[7:1]};
   assign bit_mask  = BIT_ONE << q.ir[11:9];
   assign bit_clear_val = q.opnd & ~bit_mask;
   assign idx_ea    = q.ptr[2] + {ACCESS_LO, q.ir[7:0]};
   assign bank_ea   = {q.bank_select_reg, q.ir[7:0]};

   mis_addr_map u_map
   (
      .fadr (q.ir[7:0]),
      .acc  (q.ir[8]),
      .ext  (q.ext),
      .bank_select_reg (q.bank_select_reg),
      .ptr2 (q.ptr[2]),
      .ea   (ea)
   );

   // Next state: bus slave first, then the four-phase instruction sequencer.
   always_comb
   begin
      logic [32:0] rv;
      logic [32:0] ov;
      logic [31:0] wv;
      logic        idle;
      rv = rd_val(q, s_axi_araddr);
      ov = rd_val(q, q.awaddr);
      wv = merge(ov[31:0], q.wdata, q.wstrb);
      idle = q.st == ST_IDLE;
      d = q;
      d.rf_we = 1'b0;
      d.rf_re = 1'b0;

      // Address and data are taken in either order and held until both are in.
      if (s_axi_awvalid && q.awready)
      begin
         d.aw_full = 1'b1;
         d.awaddr = {s_axi_awaddr[AXI_AW-1:2], 2'h0};
      end
      if (s_axi_wvalid && q.wready)
      begin
         d.w_full = 1'b1;
         d.wdata = s_axi_wdata;
         d.wstrb = s_axi_wstrb;
      end
      if (q.bvalid && s_axi_bready)
         d.bvalid = 1'b0;
      // State writes are refused while busy, except an instruction write in ST_WAIT2, so software cannot race the sequencer.
      if (q.aw_full && q.w_full && !q.bvalid)
      begin
         d.aw_full = 1'b0;
         d.w_full = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = ov[32] ? RESP_OKAY : RESP_SLVERR;
         case (q.awaddr)
            REG_CTRL:  if (idle) d.ext = wv[0];
            REG_INSTR:
               if (idle || q.st == ST_WAIT2)
               begin
                  d.ir = wv[15:0];
                  d.call2 = q.st == ST_WAIT2;
                  d.st = ST_EXEC;
                  d.ph = PH_Q1;
                  if (idle)
                     d.call_err = 1'b0;
               end
            REG_FLAGS: if (idle) d.flags = wv[7:0];
            REG_WORK:  if (idle) d.w = wv[7:0];
            REG_BANK:  if (idle) d.bank_select_reg = wv[3:0];
            REG_PC:    if (idle) d.pc = wv[PC_W-1:0];
            REG_STACK_TOP: if (idle) d.return_stack_top = wv[PC_W-1:0];
            REG_PTR0:  if (idle) d.ptr[0] = wv[PTR_W-1:0];
            REG_PTR1:  if (idle) d.ptr[1] = wv[PTR_W-1:0];
            REG_PTR2:  if (idle) d.ptr[2] = wv[PTR_W-1:0];
            default: ;
         endcase
      end
      if (q.rvalid && s_axi_rready)
         d.rvalid = 1'b0;
      if (s_axi_arvalid && q.arready)
      begin
         d.rvalid = 1'b1;
         d.rdata = rv[31:0];
         d.rresp = rv[32] ? RESP_OKAY : RESP_SLVERR;
      end

      case (q.st)
         ST_EXEC:
         begin
            d.ph = q.ph + PH_STEP;
            case (q.ph)
               PH_Q1:
               begin
                  d.pc = q.pc + PC_STEP;
                  if (op_file)
                  begin
                     d.rf_re = 1'b1;
                     d.rf_addr = ea;
                  end
               end
               PH_Q2:
               begin
                  if (op_call)
                  begin
                     d.k_lo = q.ir[7:0];
                     d.call_s = q.ir[8];
                  end
               end
               PH_Q3:
               begin
                  d.opnd = rf_rdata;
                  if (op_rrnc)
                     d.res = {rf_rdata[0], rf_rdata[7:1]};
                  else if (bit_clear_op)
                     d.res = rf_rdata & ~bit_mask;
                  else
                     d.res = BYTE_ONES;
                  // The return address goes on the stack before PC moves.
                  if (q.call2 && word2_ok)
                  begin
                     d.return_stack_top = q.pc;
                     if (q.call_s)
                     begin
                        d.work_shadow = q.w;
                        d.flags_shadow = q.flags;
                        d.bank_select_shadow = q.bank_select_reg;
                     end
                  end
               end
               default:
               begin
                  d.st = ST_IDLE;
                  if (op_file && dest_file)
                  begin
                     d.rf_we = 1'b1;
                     d.rf_wdata = q.res;
                  end
                  if (op_rrnc)
                  begin
                     if (!q.ir[9])
                        d.w = q.res;
                     d.flags[FLAG_Z] = q.res == BYTE_ZERO;
                     d.flags[FLAG_N] = q.res[7];
                  end
                  if (branch_on_zero_op && zero_set)
                  begin
                     d.pc = branch_target;
                     d.st = ST_NOP;
                  end
                  if (op_ptr)
                     d.ptr[ptr_sel] = ptr_sum;
                  if (op_ret)
                  begin
                     d.pc = q.return_stack_top;
                     d.st = ST_NOP;
                  end
                  if (op_call)
                     d.st = ST_WAIT2;
                  // A bad second word drops the call and leaves the stack alone.
                  if (q.call2)
                  begin
                     if (word2_ok)
                     begin
                        d.pc = call_target;
                        d.st = ST_NOP;
                     end
                     else
                        d.call_err = 1'b1;
                  end
               end
            endcase
         end
         ST_NOP:
         begin
            d.ph = q.ph + PH_STEP;
            if (q.ph == PH_Q4)
               d.st = ST_IDLE;
         end
         default: ;
      endcase

      d.awready = !d.aw_full && !d.bvalid;
      d.wready = !d.w_full && !d.bvalid;
      d.arready = !d.rvalid;
   end

   // State register; every output below is a field of it.
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         q <= '0;
         q.st <= ST_IDLE;
      end
      else
         q <= d;
   end

   assign s_axi_awready = q.awready;
   assign s_axi_wready  = q.wready;
   assign s_axi_bvalid  = q.bvalid;
   assign s_axi_bresp   = q.bresp;
   assign s_axi_arready = q.arready;
   assign s_axi_rvalid  = q.rvalid;
   assign s_axi_rdata   = q.rdata;
   assign s_axi_rresp   = q.rresp;
   assign rf_addr       = q.rf_addr;
   assign rf_re         = q.rf_re;
   assign rf_we         = q.rf_we;
   assign rf_wdata      = q.rf_wdata;

   // Checks on the sequencer, one clock domain throughout.
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   logic at_q1, at_q3, at_q4;
   assign at_q1 = (q.st == ST_EXEC) && (q.ph == PH_Q1);
   assign at_q3 = (q.st == ST_EXEC) && (q.ph == PH_Q3);
   assign at_q4 = (q.st == ST_EXEC) && (q.ph == PH_Q4);

   property p_branch_taken;
      at_q4 && branch_on_zero_op && zero_set |=>
         q.pc == $past(branch_target) && q.st == ST_NOP;
   endproperty
   a_branch_taken: assert property (p_branch_taken) else $error("branch pc wrong");

   property p_branch_nop;
      at_q4 && branch_on_zero_op && zero_set |=>
         (q.st == ST_NOP) [*4] ##1 q.st == ST_IDLE;
   endproperty
   a_branch_nop: assert property (p_branch_nop) else $error("branch nop wrong");

   property p_branch_skip;
      at_q4 && branch_on_zero_op && !zero_set |=>
         q.st == ST_IDLE && q.pc == $past(q.pc);
   endproperty
   a_branch_skip: assert property (p_branch_skip) else $error("untaken branch moved pc");

   property p_call_push;
      at_q4 && q.call2 && word2_ok |->
         q.return_stack_top == q.pc ##1 q.pc == $past(call_target);
   endproperty
   a_call_push: assert property (p_call_push) else $error("call push wrong");

   property p_call_shadow;
      at_q3 && q.call2 && word2_ok |=>
         q.work_shadow == ($past(q.call_s) ? $past(q.w) : $past(q.work_shadow)) &&
         q.flags_shadow == ($past(q.call_s) ? $past(q.flags) : $past(q.flags_shadow)) &&
         q.bank_select_shadow ==
            ($past(q.call_s) ? $past(q.bank_select_reg) : $past(q.bank_select_shadow));
   endproperty
   a_call_shadow: assert property (p_call_shadow) else $error("shadow copy wrong");

   property p_call_first;
      at_q4 && op_call |=>
         q.st == ST_WAIT2 && q.return_stack_top == $past(q.return_stack_top);
   endproperty
   a_call_first: assert property (p_call_first) else $error("call word one wrong");

   property p_rrnc_file;
      at_q4 && op_rrnc && q.ir[9] |=> q.rf_we && q.rf_wdata == $past(rot_opnd) &&
         q.flags[FLAG_Z] == (q.rf_wdata == BYTE_ZERO);
   endproperty
   a_rrnc_file: assert property (p_rrnc_file) else $error("rotate to file wrong");

   property p_rrnc_work;
      at_q4 && op_rrnc && !q.ir[9] |=> !q.rf_we && q.w == $past(rot_opnd) &&
         q.flags[FLAG_N] == q.w[7];
   endproperty
   a_rrnc_work: assert property (p_rrnc_work) else $error("rotate to work wrong");

   property p_bank;
      at_q1 && op_file && q.ir[8] |=> q.rf_re && q.rf_addr == $past(bank_ea);
   endproperty
   a_bank: assert property (p_bank) else $error("bank address wrong");

   property p_index;
      at_q1 && op_file && !q.ir[8] && q.ext && (q.ir[7:0] <= ACCESS_LIMIT) |=>
         q.rf_addr == $past(idx_ea);
   endproperty
   a_index: assert property (p_index) else $error("indexed address wrong");

   property p_ptr_add;
      at_q4 && op_ptr && !op_ret |=> q.st == ST_IDLE && q.flags == $past(q.flags) &&
         ptr_total == $past(ptr_total) + {6'h00, $past(lit6)};
   endproperty
   a_ptr_add: assert property (p_ptr_add) else $error("pointer add wrong");

   property p_ret;
      at_q4 && op_ret |=> q.pc == $past(q.return_stack_top) &&
         ptr_total == $past(ptr_total) + {6'h00, $past(lit6)};
   endproperty
   a_ret: assert property (p_ret) else $error("add and return wrong");

   property p_ret_nop;
      at_q4 && op_ret |=> (q.st == ST_NOP) [*4] ##1 q.st == ST_IDLE;
   endproperty
   a_ret_nop: assert property (p_ret_nop) else $error("return nop wrong");

   property p_bit_clear;
      at_q4 && bit_clear_op |=> q.rf_we && q.rf_wdata == $past(bit_clear_val);
   endproperty
   a_bit_clear: assert property (p_bit_clear) else $error("bit clear wrong");

   property p_set_ones;
      at_q4 && set_all_ones_op |=> q.rf_we && q.rf_wdata == BYTE_ONES &&
         q.flags == $past(q.flags);
   endproperty
   a_set_ones: assert property (p_set_ones) else $error("set register wrong");

   property p_phases;
      at_q1 |=> q.ph == PH_Q2 ##1 q.ph == PH_Q3 ##1 at_q4;
   endproperty
   a_phases: assert property (p_phases) else $error("phase order wrong");

   c_branch_taken: cover property (at_q4 && branch_on_zero_op && zero_set);
   c_call_shadow: cover property (at_q3 && q.call2 && word2_ok && q.call_s);
   c_ret: cover property (at_q4 && op_ret);
endmodule

// ===== sim/mis_exec_core_tb_top.sv
// Self-checking bench for the instruction subset execute unit.
`timescale 1ns/10ps
module mis_exec_core_tb_top;
   import mis_pkg::*;
   logic        core_clk, sys_rst, rf_re, rf_we;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, rf_wdata, rf_rdata;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [11:0] rf_addr;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, s_axi_bready;
   logic [7:0]  ram [4096];
   int          fail_count, checks;

   mis_exec_core dut (.core_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rf_addr, .rf_re, .rf_we, .rf_wdata,
      .rf_rdata);

   // Data RAM with one cycle of read latency, as the unit samples in its third phase.
   always @(posedge core_clk)
   begin
      if (rf_we) ram[rf_addr] <= rf_wdata;
      rf_rdata <= ram[rf_addr];
   end

   // The 100 ns clock.
   initial
   begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   task automatic close_out();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      checks++;
      if (s !== e)
      begin
         fail_count++;
         $display("MISMATCH %s expected %0h seen %0h", nm, e, s);
      end
   endtask

   // A used-up wait is a mismatch and ends the run, so a hang never eats the budget.
   task automatic tmo(input int n);
      if (n >= 60)
      begin
         fail_count++;
         $display("MISMATCH wait expected done seen timeout");
         close_out();
      end
   endtask

   // Write and read hold each valid until its own ready; bready and rready stay high.
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      int n;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      n = 0;
      do
      begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         n++;
      end while (!s_axi_bvalid && n < 60);
      rs = s_axi_bresp;
      tmo(n);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      int n;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      n = 0;
      do
      begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         n++;
      end while (!s_axi_rvalid && n < 60);
      v = s_axi_rdata;
      rs = s_axi_rresp;
      tmo(n);
   endtask

   // Every mapped access in the scenarios must answer OKAY.
   task automatic w(input logic [7:0] a, input logic [31:0] v);
      wr(a, v, r);
      chk("wr resp okay", RESP_OKAY, r);
   endtask

   task automatic ex(input logic [7:0] a, input logic [31:0] e);
      rd(a, d, r);
      chk("rd resp okay", RESP_OKAY, r);
      chk($sformatf("reg %0h", a), e, d);
   endtask

   // Issue one word and wait until it is done or a second call word is awaited.
   task automatic go(input logic [31:0] op);
      int n;
      w(REG_INSTR, op);
      n = 0;
      do
      begin
         rd(REG_STATUS, d, r);
         n++;
      end while (d[0] !== 1'b0 && d[1] !== 1'b1 && n < 60);
      tmo(n);
   endtask

   task automatic t_bus();
      rd(8'h80, d, r);
      chk("rd resp", RESP_SLVERR, r);
      chk("rd data", 32'h0, d);
      wr(8'h80, 32'h1, r);
      chk("wr resp", RESP_SLVERR, r);
   endtask

   task automatic t_branch();
      w(REG_FLAGS, 32'h04);
      w(REG_PC, 32'h10);
      go(32'hE0FE);
      ex(REG_PC, 32'h0E);
      w(REG_FLAGS, 32'h0);
      go(32'hE005);
      ex(REG_PC, 32'h10);
   endtask

   task automatic t_call();
      w(REG_WORK, 32'h5A);
      w(REG_FLAGS, 32'h14);
      w(REG_BANK, 32'h3);
      w(REG_PC, 32'h100);
      go(32'hED34);
      go(32'hF012);
      ex(REG_PC, 32'h2468);
      ex(REG_STACK_TOP, 32'h104);
      ex(REG_SHADOW, 32'h3145A);
      w(REG_WORK, 32'h11);
      go(32'hEC00);
      go(32'hF000);
      ex(REG_SHADOW, 32'h3145A);
      ex(REG_STACK_TOP, 32'h246C);
      go(32'hEC00);
      go(32'h0000);
      ex(REG_STATUS, 32'h104);
      ex(REG_STACK_TOP, 32'h246C);
      ex(REG_PC, 32'h4);
   endtask

   task automatic t_ptr();
      w(REG_PTR0, 32'h3FF);
      w(REG_PTR2, 32'h3FF);
      go(32'hE823);
      ex(REG_PTR0, 32'h422);
      ex(REG_FLAGS, 32'h14);
      go(32'hE8E3);
      ex(REG_PTR2, 32'h422);
      ex(REG_PC, 32'h246C);
   endtask

   task automatic t_byte();
      ram[12'h020] = 8'hD7;
      go(32'h4220);
      chk("ram 20", 32'hEB, ram[12'h020]);
      ex(REG_FLAGS, 32'h10);
      go(32'h4020);
      ex(REG_WORK, 32'hF5);
      chk("ram 20", 32'hEB, ram[12'h020]);
      w(REG_BANK, 32'h2);
      go(32'h6910);
      chk("ram 210", 32'hFF, ram[12'h210]);
      w(REG_CTRL, 32'h1);
      w(REG_PTR2, 32'h300);
      go(32'h6805);
      chk("ram 305", 32'hFF, ram[12'h305]);
      go(32'h6880);
      chk("ram F80", 32'hFF, ram[12'hF80]);
      ex(REG_FLAGS, 32'h10);
      w(REG_CTRL, 32'h0);
      ram[12'h040] = 8'hC7;
      go(32'h9E40);
      chk("ram 40", 32'h47, ram[12'h040]);
   endtask

   // Main sequence: reset for 16 cycles, then each scenario in turn.
   initial
   begin
      foreach (ram[i]) ram[i] = 8'h00;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
      sys_rst = 1'b1;
      repeat (16) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      t_bus();
      t_branch();
      t_call();
      t_ptr();
      t_byte();
      close_out();
   end
endmodule
